// ===== sim/temp_limit_status_regs_tb.sv
`timescale 1ns/1ns
module temp_limit_status_regs_tb;
   localparam int TMO = 20;
   logic mclk, rstn, reg_wr, reg_rd, shutdown_mode, conv_start, conv_done;
   logic [2:0] reg_ptr;
   logic [15:0] reg_wdata, reg_rdata, temp_data, upper_threshold;
   logic alert_polarity_sel, alert_disable, alert_clear_cmd, ara_clear;
   logic alert_pin, alert_oe, smbclk, smbdat, bus_timeout_off, bus_timeout;
   logic frame, stuck;
   tlsr_pkg::tlsr_res_t precision_sel;
   int compares = 0;
   int miscompares = 0;
   int tmo_seen = 0;

   tlsr_regs #(.TIMEOUT_CYC(TMO)) u_tlsr_regs (
      .mclk(mclk), .rstn(rstn), .reg_ptr(reg_ptr), .reg_wr(reg_wr), .reg_wdata(reg_wdata),
      .reg_rd(reg_rd), .reg_rdata(reg_rdata), .shutdown_mode(shutdown_mode), .conv_start(conv_start),
      .conv_done(conv_done), .temp_data(temp_data), .precision_sel(precision_sel),
      .upper_threshold(upper_threshold), .alert_polarity_sel(alert_polarity_sel),
      .alert_disable(alert_disable), .alert_clear_cmd(alert_clear_cmd), .ara_clear(ara_clear),
      .alert_pin(alert_pin), .alert_oe(alert_oe), .smbclk(smbclk), .smbdat(smbdat),
      .bus_timeout_off(bus_timeout_off), .bus_timeout(bus_timeout)
   );

   tlsr_bus_host u_tlsr_bus_host (.frame(frame), .stuck(stuck), .smbclk(smbclk), .smbdat(smbdat));

   // ****************************************
   // Clock, watchdog, time-out pulse counter
   // ****************************************
   initial begin
      mclk = 1'b0;
      forever #50 mclk = ~mclk;
   end

   // Whole run is under 2000 cycles; this leaves ample slack
   initial begin
      #500000;
      miscompares++;
      results();
   end

   always @(posedge mclk) begin
      if (bus_timeout === 1'b1) begin
         tmo_seen <= tmo_seen + 1;
      end
   end

   // ****************************************
   // Access tasks
   // ****************************************
   task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
      compares++;
      if (g !== e) begin
         miscompares++;
         $display("unexpected %s: expected %h, seen %h", nm, e, g);
      end
   endtask : chk

   task automatic step();
      @(posedge mclk);
      #10;
   endtask : step

   task automatic wr(input logic [2:0] p, input logic [15:0] d);
      step();
      reg_ptr = p;
      reg_wdata = d;
      reg_wr = 1'b1;
      step();
      reg_wr = 1'b0;
   endtask : wr

   task automatic rd(input logic [2:0] p, input logic [15:0] e);
      step();
      reg_ptr = p;
      repeat (2) step();
      chk("read data", e, reg_rdata);
   endtask : rd

   // Flag-clearing read of the control byte
   task automatic clr();
      step();
      reg_ptr = 3'h4;
      reg_rd = 1'b1;
      step();
      reg_rd = 1'b0;
   endtask : clr

   // Event pulse: 0 conversion start, 1 alert clear, 2 response sequence
   task automatic ev(input int k);
      step();
      conv_start = (k == 0);
      alert_clear_cmd = (k == 1);
      ara_clear = (k == 2);
      step();
      {conv_start, alert_clear_cmd, ara_clear} = 3'h0;
      repeat (2) step();
   endtask : ev

   task automatic cv(input logic [15:0] t);
      step();
      temp_data = t;
      conv_done = 1'b1;
      step();
      conv_done = 1'b0;
      repeat (2) step();
   endtask : cv

   task automatic results();
      $display("compares %0d, miscompares %0d", compares, miscompares);
      if (miscompares == 0 && compares > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask : results

   // ****************************************
   // Test sequence
   // ****************************************
   initial begin
      rstn = 1'b0;
      {reg_wr, reg_rd, conv_start, conv_done, alert_clear_cmd, ara_clear} = 6'h00;
      {shutdown_mode, alert_polarity_sel, alert_disable, frame, stuck} = 5'h00;
      reg_ptr = 3'h0;
      reg_wdata = 16'h0000;
      temp_data = 16'h0000;
      upper_threshold = 16'h1900;
      repeat (12) @(posedge mclk);
      #10;
      rstn = 1'b1;
      rd(3'h3, 16'h8000); // lower limit reset
      rd(3'h4, 16'h0009); // control reset, done high
      wr(3'h3, 16'hFFFF); // host writes ones to probe padding
      rd(3'h3, 16'hFFE0); // low bits zero
      wr(3'h3, 16'h0000); // lower limit back to zero
      wr(3'h4, 16'h00FF); // every control bit written
      rd(3'h4, 16'h00E9); // reserved and status ignore writes
      chk("timeout off", 16'h0001, {15'h0, bus_timeout_off}); // control bit 7
      // Sample just above the upper limit only at 13 and 14 bits
      for (int i = 0; i < 4; i++) begin
         wr(3'h4, {8'h00, 1'b0, i[1:0], 5'h00}); // resolution select
         chk("precision", {14'h0, i[1:0]}, {14'h0, precision_sel}); // select field
         cv(16'h1908); // one conversion per setting
         rd(3'h4, {8'h00, 1'b0, i[1:0], 5'h00} | ((i > 1) ? 16'h0005 : 16'h0009)); // masked
      end
      clr(); // read while still over
      rd(3'h4, 16'h0065); // still over, kept
      cv(16'h1000); // back inside the limits
      rd(3'h4, 16'h0065); // history kept
      clr(); // read once back inside
      rd(3'h4, 16'h0061); // over flag cleared by read
      ev(1); // alert clear command
      chk("alert pin", 16'h0001, {15'h0, alert_pin}); // clear command
      rd(3'h4, 16'h0069); // status follows pin
      wr(3'h3, 16'h0A00); // lower limit inside range
      cv(16'h2000); // above upper limit
      rd(3'h4, 16'h0065); // over sets alert
      cv(16'h0800); // below lower limit
      chk("alert pin", 16'h0001, {15'h0, alert_pin}); // below lower releases
      rd(3'h4, 16'h006F); // under flag set
      clr(); // read while still below
      rd(3'h4, 16'h006B); // under kept, over cleared
      cv(16'h1000); // back inside the limits
      clr(); // read once back inside
      rd(3'h4, 16'h0069); // under cleared by read
      cv(16'h2000); // alert active again
      ev(2); // response address sequence
      chk("alert pin", 16'h0001, {15'h0, alert_pin}); // response sequence
      cv(16'h2000); // alert active again
      alert_polarity_sel = 1'b1;
      repeat (3) step();
      chk("alert pin", 16'h0001, {15'h0, alert_pin}); // active high
      chk("alert enable", 16'h0000, {15'h0, alert_oe}); // released while high
      rd(3'h4, 16'h006D); // status is pin level
      alert_disable = 1'b1;
      repeat (2) step();
      chk("alert pin", 16'h0000, {15'h0, alert_pin}); // forced inactive
      chk("alert enable", 16'h0001, {15'h0, alert_oe}); // pulled low while inactive
      rd(3'h4, 16'h0065); // status follows forced pin
      alert_disable = 1'b0;
      repeat (2) step();
      chk("alert pin", 16'h0001, {15'h0, alert_pin}); // latch kept while disabled
      ev(1); // alert clear command
      rd(3'h4, 16'h0065); // cleared to inactive low
      shutdown_mode = 1'b1;
      ev(0); // one-shot start
      rd(3'h4, 16'h0064); // converting reads zero
      cv(16'h1000); // one-shot finishes
      rd(3'h4, 16'h0065); // done read high after the one-shot
      // ****************************************
      // Bus lines and idle time-out
      // ****************************************
      frame = 1'b1;
      repeat (160) step();
      frame = 1'b0;
      repeat (12) step();
      chk("timeout count", 16'h0000, tmo_seen[15:0]); // normal traffic
      stuck = 1'b1;
      repeat (30) step();
      stuck = 1'b0;
      repeat (4) step();
      chk("timeout count", 16'h0001, tmo_seen[15:0]); // clock held low
      wr(3'h4, 16'h00E0); // time-out off
      stuck = 1'b1;
      repeat (30) step();
      stuck = 1'b0;
      repeat (4) step();
      chk("timeout count", 16'h0001, tmo_seen[15:0]); // timers stopped
      results();
   end
endmodule : temp_limit_status_regs_tb

// ===== sim/tlsr_bus_host.sv
`timescale 1ns/1ns
module tlsr_bus_host (
   // Frame control from the bench
   input wire logic frame,
   input wire logic stuck,
   // Bus lines, pulled up when released
   output logic smbclk,
   output logic smbdat
);
   // ****************************************
   // Two-wire traffic, 800 ns bit time
   // ****************************************
   // Clock stands high between frames; stuck holds it low to provoke the idle timer
   initial begin
      smbclk = 1'b1;
      smbdat = 1'b1;
      forever begin
         wait (frame || stuck);
         if (stuck) begin
            smbclk = 1'b0;
            wait (!stuck);
            smbclk = 1'b1;
         end else begin
            #400;
            smbclk = 1'b0;
            smbdat = ~smbdat;
            #400;
            smbclk = 1'b1;
         end
         if (!frame) begin
            smbdat = 1'b1;
         end
      end
   end
endmodule : tlsr_bus_host

// ===== verilog/tlsr_bus_timer.sv
`timescale 1ns/1ns
module tlsr_bus_timer #(
   parameter int TIMEOUT_CYC = tlsr_pkg::BUS_TIMEOUT_CYC
) (
   // Clock and reset
   input wire logic mclk,
   input wire logic rstn,
   // Bus lines, asynchronous to mclk
   input wire logic smbclk,
   input wire logic smbdat,
   // Control and result
   input wire logic bus_timeout_off,
   output logic bus_timeout
);

   logic [1:0] clk_sync_r;
   logic [1:0] dat_sync_r;
   logic [tlsr_pkg::TMO_CNT_W-1:0] cnt_r, cnt_nxt;
   logic tmo_r, tmo_nxt;
   logic [tlsr_pkg::TMO_CNT_W-1:0] limit;
   logic line_low;

   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         clk_sync_r <= 2'h3;
         dat_sync_r <= 2'h3;
      end else begin
         clk_sync_r <= {clk_sync_r[0], smbclk};
         dat_sync_r <= {dat_sync_r[0], smbdat};
      end
   end

   // Either line stuck low counts; the wait restarts once both lines are high or the time-out is switched off
   always_comb begin
      limit = tlsr_pkg::TMO_CNT_W'(TIMEOUT_CYC - 1);
      line_low = !clk_sync_r[1] || !dat_sync_r[1];
      cnt_nxt = cnt_r;
      tmo_nxt = 1'b0;
      if (bus_timeout_off || !line_low) begin
         cnt_nxt = '0;
      end else if (cnt_r != limit) begin
         cnt_nxt = cnt_r + 1'b1;
         tmo_nxt = (cnt_r + 1'b1) == limit;
      end
   end

   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         cnt_r <= '0;
         tmo_r <= 1'b0;
      end else begin
         cnt_r <= cnt_nxt;
         tmo_r <= tmo_nxt;
      end
   end

   assign bus_timeout = tmo_r;

   a_timeout_off: assert property (@(posedge mclk) disable iff (!rstn)
      bus_timeout_off |=> !bus_timeout && cnt_r == '0)
      else $error("time-out counted while disabled");

endmodule : tlsr_bus_timer

// ===== verilog/tlsr_limit_cmp.sv
`timescale 1ns/1ns
module tlsr_limit_cmp (
   // Clock and reset
   input wire logic mclk,
   input wire logic rstn,
   // Conversion result and limits
   input wire logic sample,
   input wire tlsr_pkg::tlsr_res_t res,
   input wire logic [15:0] temp_data,
   input wire logic [15:0] upper_threshold,
   input wire logic [tlsr_pkg::LIM_W-1:0] lower_lim,
   // Comparison state
   output logic over_now,
   output logic under_now,
   output logic over_hit,
   output logic under_hit
);

   logic [15:0] mask;
   logic signed [15:0] temp_m;
   logic signed [15:0] upper_s;
   logic signed [15:0] lower_s;
   logic over_now_r, over_now_nxt;
   logic under_now_r, under_now_nxt;
   logic over_hit_r, over_hit_nxt;
   logic under_hit_r, under_hit_nxt;

   always_comb begin
      unique case (res)
         tlsr_pkg::RES_11B: mask = tlsr_pkg::MASK_11B;
         tlsr_pkg::RES_12B: mask = tlsr_pkg::MASK_12B;
         tlsr_pkg::RES_13B: mask = tlsr_pkg::MASK_13B;
         tlsr_pkg::RES_14B: mask = tlsr_pkg::MASK_14B;
      endcase
   end

   always_comb begin
      temp_m = $signed(temp_data & mask);
      upper_s = $signed({upper_threshold[tlsr_pkg::LIM_MSB:tlsr_pkg::LIM_LSB], tlsr_pkg::LIM_PAD});
      lower_s = $signed({lower_lim, tlsr_pkg::LIM_PAD});
      over_now_nxt = over_now_r;
      under_now_nxt = under_now_r;
      over_hit_nxt = 1'b0;
      under_hit_nxt = 1'b0;
      if (sample) begin
         over_now_nxt = temp_m > upper_s;
         under_now_nxt = temp_m < lower_s;
         over_hit_nxt = temp_m > upper_s;
         under_hit_nxt = temp_m < lower_s;
      end
   end

   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         over_now_r <= 1'b0;
         under_now_r <= 1'b0;
         over_hit_r <= 1'b0;
         under_hit_r <= 1'b0;
      end else begin
         over_now_r <= over_now_nxt;
         under_now_r <= under_now_nxt;
         over_hit_r <= over_hit_nxt;
         under_hit_r <= under_hit_nxt;
      end
   end

   assign over_now = over_now_r;
   assign under_now = under_now_r;
   assign over_hit = over_hit_r;
   assign under_hit = under_hit_r;

   a_hit_tracks_now: assert property (@(posedge mclk) disable iff (!rstn)
      over_hit |-> over_now && !under_hit)
      else $error("over hit without over state");

endmodule : tlsr_limit_cmp

// ===== verilog/tlsr_pkg.sv
package tlsr_pkg;

   // ****************************************
   // Register map, as seen through the pointer
   // ****************************************
   localparam int PTR_W = 3;
   localparam logic [2:0] PTR_LOWER = 3'h3;
   localparam logic [2:0] PTR_CTRL = 3'h4;

   localparam int DATA_W = 16;
   localparam int LIM_MSB = 15;
   localparam int LIM_LSB = 5;
   localparam int LIM_W = LIM_MSB - LIM_LSB + 1;
   localparam logic [15:0] LOWER_RST = 16'h8000;
   localparam logic [4:0] LIM_PAD = 5'h00;

   // ****************************************
   // Control/status byte layout
   // ****************************************
   localparam logic [7:0] CTRL_RST = 8'h08;
   localparam int BIT_TO_OFF = 7;
   localparam int BIT_RES_HI = 6;
   localparam int BIT_RES_LO = 5;
   localparam int BIT_RSV = 4;
   localparam int BIT_ALERT = 3;
   localparam int BIT_OVER = 2;
   localparam int BIT_UNDER = 1;
   localparam int BIT_DONE = 0;
   localparam logic [7:0] UPPER_ZERO = 8'h00;

   // ****************************************
   // Resolution select and the valid bits of each
   // ****************************************
   typedef enum logic [1:0] {RES_11B, RES_12B, RES_13B, RES_14B} tlsr_res_t;
   localparam logic [15:0] MASK_11B = 16'hFFE0;
   localparam logic [15:0] MASK_12B = 16'hFFF0;
   localparam logic [15:0] MASK_13B = 16'hFFF8;
   localparam logic [15:0] MASK_14B = 16'hFFFC;

   // ****************************************
   // Bus-idle time-out
   // ****************************************
   localparam int MCLK_KHZ = 10000;
   localparam int BUS_TIMEOUT_US = 30000;
   localparam int BUS_TIMEOUT_CYC = BUS_TIMEOUT_US * MCLK_KHZ / 1000;
   localparam int TMO_CNT_W = 19;

endpackage : tlsr_pkg

// ===== verilog/tlsr_regs.sv
`timescale 1ns/1ns
module tlsr_regs #(
   parameter int TIMEOUT_CYC = tlsr_pkg::BUS_TIMEOUT_CYC
) (
   // Clock and reset
   input wire logic mclk,
   input wire logic rstn,
   // Register access from the serial engine
   input wire logic [tlsr_pkg::PTR_W-1:0] reg_ptr,
   input wire logic reg_wr,
   input wire logic [15:0] reg_wdata,
   input wire logic reg_rd,
   output logic [15:0] reg_rdata,
   // Conversion engine
   input wire logic shutdown_mode,
   input wire logic conv_start,
   input wire logic conv_done,
   input wire logic [15:0] temp_data,
   output tlsr_pkg::tlsr_res_t precision_sel,
   // Neighbouring registers and alert controls
   input wire logic [15:0] upper_threshold,
   input wire logic alert_polarity_sel,
   input wire logic alert_disable,
   input wire logic alert_clear_cmd,
   input wire logic ara_clear,
   // Alert pin, open drain
   output logic alert_pin,
   output logic alert_oe,
   // Bus lines and time-out
   input wire logic smbclk,
   input wire logic smbdat,
   output logic bus_timeout_off,
   output logic bus_timeout
);

   // ****************************************
   // Stored fields
   // ****************************************
   logic [tlsr_pkg::LIM_W-1:0] lower_r, lower_nxt;
   logic to_off_r, to_off_nxt;
   tlsr_pkg::tlsr_res_t res_r, res_nxt;
   logic alert_r, alert_nxt;
   logic level_r, level_nxt;
   logic over_r, over_nxt;
   logic under_r, under_nxt;
   logic done_r, done_nxt;
   logic [15:0] rdata_r, rdata_nxt;

   logic over_now, under_now, over_hit, under_hit;
   logic wr_lower, wr_ctrl, rd_ctrl;
   logic done_view;
   logic [7:0] ctrl_byte;

   assign wr_lower = reg_wr && reg_ptr == tlsr_pkg::PTR_LOWER;
   assign wr_ctrl = reg_wr && reg_ptr == tlsr_pkg::PTR_CTRL;
   assign rd_ctrl = reg_rd && reg_ptr == tlsr_pkg::PTR_CTRL;

   // ****************************************
   // Limit comparison and bus timer
   // ****************************************
   tlsr_limit_cmp u_cmp (
      .mclk(mclk),
      .rstn(rstn),
      .sample(conv_done),
      .res(res_r),
      .temp_data(temp_data),
      .upper_threshold(upper_threshold),
      .lower_lim(lower_r),
      .over_now(over_now),
      .under_now(under_now),
      .over_hit(over_hit),
      .under_hit(under_hit)
   );

   tlsr_bus_timer #(
      .TIMEOUT_CYC(TIMEOUT_CYC)
   ) u_timer (
      .mclk(mclk),
      .rstn(rstn),
      .smbclk(smbclk),
      .smbdat(smbdat),
      .bus_timeout_off(to_off_r),
      .bus_timeout(bus_timeout)
   );

   // ****************************************
   // Register writes
   // ****************************************
   always_comb begin
      lower_nxt = lower_r;
      to_off_nxt = to_off_r;
      res_nxt = res_r;
      if (wr_lower) begin
         lower_nxt = reg_wdata[tlsr_pkg::LIM_MSB:tlsr_pkg::LIM_LSB];
      end
      if (wr_ctrl) begin
         to_off_nxt = reg_wdata[tlsr_pkg::BIT_TO_OFF];
         res_nxt = tlsr_pkg::tlsr_res_t'(reg_wdata[tlsr_pkg::BIT_RES_HI:tlsr_pkg::BIT_RES_LO]);
      end
   end

   // ****************************************
   // Alert, flags and conversion status
   // ****************************************
   // Every flag lets a same-cycle set win over its clear, so no event is lost
   always_comb begin
      alert_nxt = alert_r;
      if (alert_clear_cmd || ara_clear || under_hit) begin
         alert_nxt = 1'b0;
      end
      if (over_hit) begin
         alert_nxt = 1'b1;
      end
      if (alert_nxt && !alert_disable) begin
         level_nxt = alert_polarity_sel;
      end else begin
         level_nxt = !alert_polarity_sel;
      end

      over_nxt = over_r;
      if (rd_ctrl && !over_now) begin
         over_nxt = 1'b0;
      end
      if (over_hit) begin
         over_nxt = 1'b1;
      end

      under_nxt = under_r;
      if (rd_ctrl && !under_now) begin
         under_nxt = 1'b0;
      end
      if (under_hit) begin
         under_nxt = 1'b1;
      end

      done_nxt = done_r;
      if (conv_start) begin
         done_nxt = 1'b0;
      end
      if (conv_done) begin
         done_nxt = 1'b1;
      end
   end

   // ****************************************
   // Read data
   // ****************************************
   // continuous mode reads done
   assign done_view = done_r || !shutdown_mode;

   assign ctrl_byte = {to_off_r, res_r, 1'b0, level_r, over_r, under_r, done_view};

   always_comb begin
      unique case (reg_ptr)
         tlsr_pkg::PTR_LOWER: rdata_nxt = {lower_r, tlsr_pkg::LIM_PAD};
         tlsr_pkg::PTR_CTRL: rdata_nxt = {tlsr_pkg::UPPER_ZERO, ctrl_byte};
         default: rdata_nxt = '0;
      endcase
   end

   // ****************************************
   // State registers
   // ****************************************
   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         lower_r <= tlsr_pkg::LOWER_RST[tlsr_pkg::LIM_MSB:tlsr_pkg::LIM_LSB];
         to_off_r <= tlsr_pkg::CTRL_RST[tlsr_pkg::BIT_TO_OFF];
         res_r <= tlsr_pkg::tlsr_res_t'(tlsr_pkg::CTRL_RST[tlsr_pkg::BIT_RES_HI:tlsr_pkg::BIT_RES_LO]);
         alert_r <= 1'b0;
         level_r <= tlsr_pkg::CTRL_RST[tlsr_pkg::BIT_ALERT];
         over_r <= tlsr_pkg::CTRL_RST[tlsr_pkg::BIT_OVER];
         under_r <= tlsr_pkg::CTRL_RST[tlsr_pkg::BIT_UNDER];
         done_r <= tlsr_pkg::CTRL_RST[tlsr_pkg::BIT_DONE];
         rdata_r <= '0;
      end else begin
         lower_r <= lower_nxt;
         to_off_r <= to_off_nxt;
         res_r <= res_nxt;
         alert_r <= alert_nxt;
         level_r <= level_nxt;
         over_r <= over_nxt;
         under_r <= under_nxt;
         done_r <= done_nxt;
         rdata_r <= rdata_nxt;
      end
   end

   // Open drain: the pin is pulled low only, high level is the release
   assign alert_pin = level_r;
   assign alert_oe = !level_r;
   assign reg_rdata = rdata_r;
   assign precision_sel = res_r;
   assign bus_timeout_off = to_off_r;

   // ****************************************
   // Checks
   // ****************************************
   default clocking cb @(posedge mclk); endclocking
   default disable iff (!rstn);

   a_lower_write: assert property (wr_lower |=> ##1 reg_ptr != tlsr_pkg::PTR_LOWER
      || reg_rdata == {$past(reg_wdata[15:5], 2), tlsr_pkg::LIM_PAD})
      else $error("lower limit readback wrong");

   a_lower_pad: assert property (reg_ptr == tlsr_pkg::PTR_LOWER |=> reg_rdata[4:0] == 5'h00)
      else $error("lower limit low bits not zero");

   a_ctrl_reserved: assert property (reg_ptr == tlsr_pkg::PTR_CTRL |=>
      reg_rdata[tlsr_pkg::BIT_RSV] == 1'b0 && reg_rdata[15:8] == 8'h00)
      else $error("reserved control bits not zero");

   a_alert_mirror: assert property (reg_ptr == tlsr_pkg::PTR_CTRL |=>
      reg_rdata[tlsr_pkg::BIT_ALERT] == $past(alert_pin))
      else $error("alert status differs from pin");

   a_over_alert: assert property (over_hit && !alert_disable |=>
      alert_pin == $past(alert_polarity_sel) && alert_oe == !$past(alert_polarity_sel))
      else $error("over limit did not assert alert");

   a_alert_release: assert property ((alert_clear_cmd || ara_clear || under_hit) && !over_hit
      |=> alert_pin == !$past(alert_polarity_sel))
      else $error("alert not released");

   a_over_sticky: assert property (over_hit ##1 (over_now && !under_hit)[*2] |-> over_r)
      else $error("over flag lost while still over");

   a_over_clear: assert property (over_r && rd_ctrl && !over_now && !over_hit |=> !over_r)
      else $error("over flag not cleared on read");

   a_under_sticky: assert property (under_r && !(rd_ctrl && !under_now) |=> under_r)
      else $error("under flag dropped without qualified read");

   a_under_set: assert property (under_hit |=> under_r)
      else $error("under flag not set");

   a_done_cont: assert property (!shutdown_mode |-> ctrl_byte[tlsr_pkg::BIT_DONE])
      else $error("done low in continuous mode");

   a_done_oneshot: assert property (shutdown_mode && conv_start && !conv_done ##1
      (shutdown_mode && !conv_done)[*3] |-> !ctrl_byte[tlsr_pkg::BIT_DONE])
      else $error("done high during one-shot conversion");

   a_over_set: assert property (over_hit |=> over_r)
      else $error("over flag not set");

   a_under_clear: assert property (under_r && rd_ctrl && !under_now && !under_hit |=> !under_r)
      else $error("under flag not cleared on read");

   a_done_set: assert property (conv_done |=> ctrl_byte[tlsr_pkg::BIT_DONE])
      else $error("done low after conversion");

   // Status bits are read-only; only the settings land
   a_ctrl_write: assert property (wr_ctrl |=> bus_timeout_off == $past(reg_wdata[tlsr_pkg::BIT_TO_OFF])
      && precision_sel == $past(reg_wdata[tlsr_pkg::BIT_RES_HI:tlsr_pkg::BIT_RES_LO]))
      else $error("control write not stored");

   // Disable forces the pin, the latch underneath keeps its state
   a_alert_off: assert property (alert_disable |=> alert_pin == !$past(alert_polarity_sel))
      else $error("alert pin active while disabled");

   // Main scenarios the bench is expected to reach
   c_over_then_read: cover property (over_hit ##[1:50] rd_ctrl);
   c_alert_off: cover property (alert_r && alert_disable);
   c_under_release: cover property (alert_r ##1 under_hit ##1 !alert_r);
   c_oneshot: cover property (shutdown_mode && conv_start ##[1:200] conv_done);
   c_timeout: cover property (bus_timeout);

endmodule : tlsr_regs
